// file: adcpp_cfg.svh
`ifndef ADCPP_CFG_SVH
`define ADCPP_CFG_SVH
`define ADCPP_RES_W 12
`define ADCPP_CH_W 3
`define ADCPP_LOW_W 8
`define ADCPP_HI_LSB 8
`define ADCPP_HI_W 4
`define ADCPP_ID_LSB 4
`define ADCPP_PAD10_W 2
`define ADCPP_WORD_RST 12'h000
`endif

// file: adcpp_pkg.sv
`include "adcpp_cfg.svh"
package adcpp_pkg;
  typedef struct packed {
    logic [`ADCPP_RES_W-1:0] data;
    logic [`ADCPP_CH_W-1:0] chan;
  } adcpp_result_t;
  typedef struct packed {
    logic [`ADCPP_RES_W-1:0] in;
    logic [`ADCPP_RES_W-1:0] out;
    logic [`ADCPP_RES_W-1:0] oe;
  } adcpp_pins_t;
  typedef enum logic [1:0] {ADCPP_IDLE, ADCPP_READ, ADCPP_WRITE} adcpp_state_t;
endpackage : adcpp_pkg

// file: adcpp_pin_map.sv
`include "adcpp_cfg.svh"
module adcpp_pin_map
  import adcpp_pkg::*;
(
  input wire logic word_mode,
  input wire logic high_byte_select,
  input wire logic ten_bit,
  input wire adcpp_result_t result,
  output logic [`ADCPP_RES_W-1:0] read_pins
);
  logic [`ADCPP_RES_W-1:0] word;
  always_comb begin
    word = result.data;
    if (ten_bit) begin
      word[`ADCPP_PAD10_W-1:0] = '0;
    end
    read_pins = '0;
    if (word_mode) begin
      read_pins = word;
    end else if (!high_byte_select) begin
      read_pins[`ADCPP_LOW_W-1:0] = word[`ADCPP_LOW_W-1:0];
    end else begin
      read_pins[`ADCPP_HI_W-1:0] = word[`ADCPP_RES_W-1:`ADCPP_HI_LSB];
      read_pins[`ADCPP_ID_LSB +: `ADCPP_CH_W] = result.chan;
    end
  end
endmodule : adcpp_pin_map

// file: adcpp_port.sv
`include "adcpp_cfg.svh"
////////////////////////////////////////////////////////////
// Summary of operation
// - Pins 0 to 7 are three-state: results out, register writes in.
// - Pins driven or sampled only with chip select and a strobe low.
// - Ten-bit variant, word or low byte read: zero on pins 0,1; result LSB on pin 2.
// - Word mode: shared pin is data bit 8, strobed like others.
// - Byte mode: shared pin is the high byte select input.
// - Byte mode, high select low: low byte on pins 0 to 7.
// - Byte mode, high select high: upper four bits on pins 0 to 3.
// - High byte read carries channel address on bits 4 to 6.
// - Ten-bit byte mode: low byte has two zero LSBs, six data bits.
// - Result driven after read strobe falls with chip select low.
// - Pins 9 to 11 carry data only in word mode.
module adcpp_port
  import adcpp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ten_bit,
  input wire adcpp_result_t result,
  input wire logic chip_sel_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic word_byte_select,
  input wire logic [`ADCPP_RES_W-1:0] pins_in,
  output logic [`ADCPP_RES_W-1:0] pins_out,
  output logic [`ADCPP_RES_W-1:0] pins_oe,
  output logic [`ADCPP_RES_W-1:0] reg_wdata,
  output logic reg_wstrobe,
  output logic [`ADCPP_RES_W-1:0] word_assembled,
  output logic high_byte_flag
);
  ////////////////////////////////////////////////////////////
  adcpp_state_t state_ff;
  adcpp_state_t nxt_state;
  logic [`ADCPP_RES_W-1:0] rd_pins;
  logic [`ADCPP_RES_W-1:0] out_ff;
  logic [`ADCPP_RES_W-1:0] wd_ff;
  logic [`ADCPP_RES_W-1:0] asm_ff;
  logic wstb_ff;
  logic hbs;
  logic rd_act;
  logic wr_act;
  logic [`ADCPP_RES_W-1:0] act_mask;
  logic take_rd;
  logic take_wr;
  logic in_read;
  logic in_write;
  logic commit_wr;
  logic wide_ff;

  ////////////////////////////////////////////////////////////
  // Lanes carried by the data pins in each width mode
  function automatic logic [`ADCPP_RES_W-1:0] lane_mask(input logic wide);
    logic [`ADCPP_RES_W-1:0] m;
    m = '0;
    if (wide) begin
      m = '1;
    end else begin
      m[`ADCPP_LOW_W-1:0] = '1;
    end
    return m;
  endfunction : lane_mask

  // Low byte from the bus over the word held so far
  function automatic logic [`ADCPP_RES_W-1:0] join_low(
    input logic [`ADCPP_RES_W-1:0] bus,
    input logic [`ADCPP_RES_W-1:0] held
  );
    return {held[`ADCPP_RES_W-1:`ADCPP_HI_LSB], bus[`ADCPP_LOW_W-1:0]};
  endfunction : join_low

  // High nibble from the bus over the low byte held so far
  function automatic logic [`ADCPP_RES_W-1:0] join_high(
    input logic [`ADCPP_RES_W-1:0] bus,
    input logic [`ADCPP_RES_W-1:0] held
  );
    return {bus[`ADCPP_HI_W-1:0], held[`ADCPP_LOW_W-1:0]};
  endfunction : join_high

  assign hbs = !word_byte_select && pins_in[`ADCPP_HI_LSB];
  assign rd_act = !chip_sel_n && !read_strobe_n;
  assign wr_act = !chip_sel_n && !write_strobe_n;

  // Access phases
  assign take_rd = state_ff == ADCPP_IDLE && rd_act;
  assign take_wr = state_ff == ADCPP_IDLE && wr_act && !rd_act;
  assign in_read = state_ff == ADCPP_READ && rd_act;
  assign in_write = state_ff == ADCPP_WRITE && wr_act;
  assign commit_wr = state_ff == ADCPP_WRITE && !wr_act;

  adcpp_pin_map u_map (
    .word_mode(word_byte_select),
    .high_byte_select(hbs),
    .ten_bit(ten_bit),
    .result(result),
    .read_pins(rd_pins)
  );

  ////////////////////////////////////////////////////////////
  // Pins in use for the current width mode
  assign act_mask = lane_mask(word_byte_select);

  ////////////////////////////////////////////////////////////
  // Access sequencer: one transfer at a time, read wins
  always_comb begin
    nxt_state = ADCPP_IDLE;
    case (state_ff)
      ADCPP_IDLE: begin
        if (rd_act) begin
          nxt_state = ADCPP_READ;
        end else if (wr_act) begin
          nxt_state = ADCPP_WRITE;
        end
      end
      ADCPP_READ: begin
        if (rd_act) begin
          nxt_state = ADCPP_READ;
        end
      end
      ADCPP_WRITE: begin
        if (wr_act) begin
          nxt_state = ADCPP_WRITE;
        end
      end
      default: begin
        nxt_state = ADCPP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= ADCPP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////
  // Read data captured at strobe start, held for the access
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_ff <= `ADCPP_WORD_RST;
    end else if (take_rd) begin
      out_ff <= rd_pins;
    end
  end

  assign pins_out = out_ff;
  assign pins_oe = in_read ? act_mask : '0;

  ////////////////////////////////////////////////////////////
  // Write data sampled while the strobe is low, committed at its rise
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wd_ff <= `ADCPP_WORD_RST;
    end else if (take_wr || in_write) begin
      wd_ff <= pins_in & act_mask;
    end
  end

  // Width mode held from the start of the write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wide_ff <= 1'b0;
    end else if (take_wr) begin
      wide_ff <= word_byte_select;
    end
  end

  // High byte select held from the start of the write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      high_byte_flag <= 1'b0;
    end else if (take_wr) begin
      high_byte_flag <= hbs;
    end
  end

  ////////////////////////////////////////////////////////////
  // One-cycle write pulse once the strobe has ended
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wstb_ff <= 1'b0;
    end else begin
      wstb_ff <= commit_wr;
    end
  end

  // Word built up from the byte lanes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      asm_ff <= `ADCPP_WORD_RST;
    end else if (commit_wr) begin
      if (wide_ff) begin
        asm_ff <= wd_ff;
      end else if (!high_byte_flag) begin
        asm_ff <= join_low(wd_ff, asm_ff);
      end else begin
        asm_ff <= join_high(wd_ff, asm_ff);
      end
    end
  end

  // Bus value handed on with each write; a high byte write adds the held low byte
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_wdata <= `ADCPP_WORD_RST;
    end else if (commit_wr) begin
      if (wide_ff || !high_byte_flag) begin
        reg_wdata <= wd_ff;
      end else begin
        reg_wdata <= join_high(wd_ff, asm_ff);
      end
    end
  end

  assign reg_wstrobe = wstb_ff;
  assign word_assembled = asm_ff;
endmodule : adcpp_port

// file: adcpp_port_assertions.sv
module adcpp_port_chk
  import adcpp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ten_bit,
  input wire adcpp_result_t result,
  input wire logic chip_sel_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic word_byte_select,
  input wire logic [11:0] pins_in,
  input wire logic [11:0] pins_out,
  input wire logic [11:0] pins_oe,
  input wire logic reg_wstrobe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire rd_on = !chip_sel_n && !read_strobe_n;
  wire [11:0] msk = {10'h3FF, {2{!ten_bit}}};
  chk_oe_strobe: assert property (|pins_oe |-> rd_on) else $error("bus driven without read");
  chk_write_undriven: assert property (!write_strobe_n |-> pins_oe == 12'h000) else $error("driven in write");
  chk_upper_off: assert property (!word_byte_select |-> pins_oe[11:8] == 4'h0) else $error("upper pins");
  chk_read_answer: assert property ($rose(rd_on) ##1 rd_on |-> pins_oe[3:0] == 4'hF) else $error("read late");
  chk_word_read: assert property (
    word_byte_select && pins_oe[0] |-> pins_out == (result.data & msk)) else $error("word read");
  chk_low_byte: assert property (
    !word_byte_select && !pins_in[8] && pins_oe[0] |-> pins_out[7:0] == (result.data[7:0] & msk[7:0]))
    else $error("low byte");
  chk_high_byte: assert property (
    !word_byte_select && pins_in[8] && pins_oe[0] |-> pins_out[6:0] == {result.chan, result.data[11:8]})
    else $error("high byte");
  chk_wstrobe_once: assert property (
    $rose(write_strobe_n) && !chip_sel_n |-> ##[1:2] reg_wstrobe ##1 !reg_wstrobe) else $error("write pulse");
endmodule : adcpp_port_chk
bind adcpp_port adcpp_port_chk u_chk (.*);

// file: adcpp_host_model.sv
module adcpp_host_model (
  input wire logic sys_clk,
  output logic chip_sel_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic word_byte_select,
  output logic [11:0] host_bus,
  output logic [11:0] host_oe,
  input wire logic [11:0] pins_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {chip_sel_n, read_strobe_n, write_strobe_n, word_byte_select, host_bus, host_oe} = {4'hF, 24'h000000};
  task automatic xfer(input logic wr, wbs, hbs, input logic [11:0] d, output logic [11:0] q);
    @(negedge sys_clk);
    word_byte_select = wbs;
    host_bus = wbs ? d : {3'h0, hbs, hbs ? {4'h0, d[3:0]} : d[7:0]};
    host_oe = wbs ? {12{wr}} : {4'h1, {8{wr}}};
    chip_sel_n = 1'b0;
    read_strobe_n = wr;
    write_strobe_n = !wr;
    repeat (2) @(negedge sys_clk);
    q = pins_in;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    @(negedge sys_clk);
    chip_sel_n = 1'b1;
    host_oe = 12'h000;
    repeat (3) @(negedge sys_clk);
  endtask : xfer
  task automatic stray(input logic [11:0] d);
    @(negedge sys_clk);
    word_byte_select = 1'b1;
    host_bus = d;
    host_oe = 12'hFFF;
    read_strobe_n = 1'b0;
    write_strobe_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_oe = 12'h000;
    repeat (3) @(negedge sys_clk);
  endtask : stray
endmodule : adcpp_host_model

// file: adc_parallel_word_byte_port_test.sv
module adc_parallel_word_byte_port_test;
  import adcpp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, reset = 1, ten_bit = 0, park = 0, reg_wstrobe, high_byte_flag;
  logic chip_sel_n, read_strobe_n, write_strobe_n, word_byte_select;
  logic [11:0] pins_in, pins_out, pins_oe, reg_wdata, word_assembled, host_bus, host_oe, q, d;
  adcpp_result_t result = '0;
  int error_cnt = 0, checks_done = 0, wcnt = 0, n0;
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) park <= ~park;
  always @(posedge sys_clk) if (reg_wstrobe === 1'b1) wcnt <= wcnt + 1;
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & host_oe & host_bus) | (~pins_oe & ~host_oe & {12{park}});
  adcpp_port uut (.*);
  adcpp_host_model host (.*);
  task automatic cmp(input logic [11:0] a, b);
    checks_done++;
    if (a !== b) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, a, b);
    end
  endtask : cmp
  task automatic report_and_stop;
    $display("Errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  function automatic logic [11:0] rexp(input logic wbs, hbs);
    logic [11:0] v;
    v = result.data & {10'h3FF, {2{!ten_bit}}};
    return wbs ? v : hbs ? {5'h00, result.chan, v[11:8]} : {4'h0, v[7:0]};
  endfunction : rexp
  initial begin
    #40000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    logic wbs;
    void'($urandom(32'h5BFE));
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk) reset = 1'b0;
    for (int i = 0; i < 60; i++) begin
      wbs = i < 4 ? i[1] : 1'($urandom);
      ten_bit = i < 4 ? i[0] : 1'($urandom);
      result = i < 4 ? '1 : 15'($urandom);
      d = 12'($urandom);
      for (int h = 0; h <= !wbs; h++) begin
        host.xfer(1'b0, wbs, h[0], 12'h000, q);
        cmp(wbs ? q : q & (h ? 12'h07F : 12'h0FF), rexp(wbs, h[0]));
      end
      n0 = wcnt;
      for (int h = 0; h <= !wbs; h++) host.xfer(1'b1, wbs, h[0], h ? d >> 8 : d, q);
      cmp(reg_wdata, d);
      cmp(word_assembled, d);
      cmp({11'h000, high_byte_flag}, {11'h000, !wbs});
      cmp(12'(wcnt - n0), wbs ? 12'h001 : 12'h002);
    end
    n0 = wcnt;
    host.stray(~d);
    cmp(word_assembled, d);
    cmp(reg_wdata, d);
    cmp(12'(wcnt - n0), 12'h000);
    report_and_stop;
  end
endmodule : adc_parallel_word_byte_port_test
